// file: shared/flm_pkg.sv
package flm_pkg;

  // array geometry
  localparam int          FLM_ADDR_W    = 19;
  localparam int          FLM_MEM_BYTES = 524288;
  localparam logic [8:0]  FLM_PAGE_MAX  = 9'h100;
  localparam logic [18:0] FLM_SECT_MASK = 19'h00fff;
  localparam logic [18:0] FLM_BLK_MASK  = 19'h0ffff;
  localparam logic [18:0] FLM_CHIP_MASK = 19'h7ffff;
  localparam logic [1:0]  FLM_ADDR_LAST = 2'h2;
  localparam logic [7:0]  FLM_ERASED    = 8'hff;

  // command codes
  localparam logic [7:0] FLM_OP_UNLOCK = 8'h06;
  localparam logic [7:0] FLM_OP_LOCK   = 8'h04;
  localparam logic [7:0] FLM_OP_RDST   = 8'h05;
  localparam logic [7:0] FLM_OP_WRST   = 8'h01;
  localparam logic [7:0] FLM_OP_READ   = 8'h03;
  localparam logic [7:0] FLM_OP_PAGE   = 8'h02;
  localparam logic [7:0] FLM_OP_SECT   = 8'h20;
  localparam logic [7:0] FLM_OP_BLK    = 8'hd8;
  localparam logic [7:0] FLM_OP_CHIP   = 8'hc7;

  // status register layout
  localparam int         FLM_ST_BUSY  = 0;
  localparam int         FLM_ST_WEL   = 1;
  localparam int         FLM_ST_PROT  = 2;
  localparam int         FLM_ST_LOCK  = 7;
  localparam logic [2:0] FLM_PROT_RST = 3'h0;

  typedef enum logic [2:0] {
    FLM_S_CMD  = 3'b000,
    FLM_S_ADDR = 3'b001,
    FLM_S_READ = 3'b010,
    FLM_S_STAT = 3'b011,
    FLM_S_PROG = 3'b100,
    FLM_S_WRST = 3'b101,
    FLM_S_ERW  = 3'b110,
    FLM_S_IGN  = 3'b111
  } flm_state_e;

endpackage : flm_pkg

// file: hdl/flm_array.sv
`timescale 1ns/100ps
module flm_array
  import flm_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_we,
  input  wire logic                  i_and,
  input  wire logic [FLM_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata
);

  logic [7:0] mem [FLM_MEM_BYTES];

  // and-mode lets a program only pull bits low
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_addr] <= i_and ? (mem[i_addr] & i_wdata) : i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_rdata <= mem[i_addr];
  end

endmodule : flm_array

// file: hdl/flm_spi_flash.sv
`timescale 1ns/100ps
// Operation
// - input bits captured on serial clock rise
// - output bits change on serial clock fall
// - chip select high: deselected, output floats
// - deselect never aborts a running erase
// - no command before first select falling edge
// - pause floats output, ignores input and clock
// - write-protect pin refuses status register writes
// - range bits alone guard array; protect pin does not
// - modes 0 and 3 use same edges
// - 524288 bytes, 2048 pages of 256
// - 128 sectors of 4 Kbyte each
// - 8 blocks of 64 Kbyte each
// - programming only clears bits to zero
// - sector, block, chip erase; no page erase
// - one page program writes 1..256 bytes
// - commands in on input, data out on output
// - program bytes stay within one page
// - pause begins only while serial clock low
module flm_spi_flash
  import flm_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_serial_in,
  input  wire logic i_hold_n,
  input  wire logic i_wp_n,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_busy,
  output logic [7:0] o_status
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_prot(input logic [2:0] rng, input logic [18:0] a);
    case (rng)
      3'h0:    is_prot = 1'b0;
      3'h1:    is_prot = (a[18:16] == 3'h7);
      3'h2:    is_prot = (a[18:17] == 2'h3);
      3'h3:    is_prot = a[18];
      default: is_prot = 1'b1;
    endcase
  endfunction : is_prot

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0]  sclk_sy_q, cs_sy_q, hold_sy_q;
  logic [1:0]  si_sy_q, wp_sy_q;
  logic        sclk_rise, sclk_fall, cs_s, cs_fall, cs_rise, hold_fall, hold_rise;
  logic        paused_q, armed_q, act, byte_done, wel_q, busy_q, lock_q, wst_pend_q;
  logic        er_last, er_go, mem_we_q, mem_and_q;
  flm_state_e  st_q;
  logic [7:0]  cmd_q, byte_in, wst_q, mem_wd_q, mem_rd, status, src;
  logic [6:0]  rx_q, sh_q;
  logic [2:0]  rx_cnt_q, prot_q, ocnt_q;
  logic [1:0]  acnt_q;
  logic [8:0]  pcnt_q;
  logic [18:0] addr_q, er_addr_q, er_mask_q, go_mask, mem_addr_q;
  ////////////////////////////////////////////////////////////////////////////////
  // two flops before use; the third only serves edge detection
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      sclk_sy_q <= 3'h0;
      cs_sy_q   <= 3'h0;
      hold_sy_q <= 3'h7;
      si_sy_q   <= 2'h0;
      wp_sy_q   <= 2'h3;
    end else begin
      sclk_sy_q <= {sclk_sy_q[1:0], i_sclk};
      cs_sy_q   <= {cs_sy_q[1:0], i_cs_n};
      hold_sy_q <= {hold_sy_q[1:0], i_hold_n};
      si_sy_q   <= {si_sy_q[0], i_serial_in};
      wp_sy_q   <= {wp_sy_q[0], i_wp_n};
    end
  end
  // edge finding is independent of the clock idle level
  assign sclk_rise = sclk_sy_q[1] & ~sclk_sy_q[2];
  assign sclk_fall = ~sclk_sy_q[1] & sclk_sy_q[2];
  assign cs_s      = cs_sy_q[1];
  assign cs_fall   = ~cs_sy_q[1] & cs_sy_q[2];
  assign cs_rise   = cs_sy_q[1] & ~cs_sy_q[2];
  assign hold_fall = ~hold_sy_q[1] & hold_sy_q[2];
  assign hold_rise = hold_sy_q[1] & ~hold_sy_q[2];
  assign act       = ~cs_s & ~paused_q & armed_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      armed_q <= 1'b0;
    end else if (cs_fall) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn || cs_s) begin
      paused_q <= 1'b0;
    end else if (hold_fall && !sclk_sy_q[1]) begin
      paused_q <= 1'b1;
    end else if (hold_rise && !sclk_sy_q[1]) begin
      paused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign byte_in   = {rx_q, si_sy_q[1]};
  assign byte_done = act && sclk_rise && (rx_cnt_q == 3'h7);
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || cs_s) begin
      rx_cnt_q <= 3'h0;
      rx_q     <= 7'h0;
    end else if (act && sclk_rise) begin
      rx_q     <= byte_in[6:0];
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end
  // command sequencing; a deselect always returns to the command byte
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || cs_s) begin
      st_q   <= FLM_S_CMD;
      acnt_q <= 2'h0;
      pcnt_q <= 9'h0;
      if (!i_rstn) begin
        cmd_q  <= 8'h0;
        addr_q <= 19'h0;
      end
    end else if (act && sclk_fall && st_q == FLM_S_READ && ocnt_q == 3'h0) begin
      addr_q <= addr_q + 19'h1;
    end else if (byte_done) begin
      case (st_q)
        FLM_S_CMD: begin
          cmd_q <= byte_in;
          if (byte_in == FLM_OP_RDST) begin
            st_q <= FLM_S_STAT;
          end else if (busy_q) begin
            st_q <= FLM_S_IGN;
          end else if (byte_in == FLM_OP_WRST) begin
            st_q <= FLM_S_WRST;
          end else if (byte_in == FLM_OP_READ || byte_in == FLM_OP_PAGE ||
                       byte_in == FLM_OP_SECT || byte_in == FLM_OP_BLK) begin
            st_q <= FLM_S_ADDR;
          end else if (byte_in == FLM_OP_CHIP) begin
            st_q <= FLM_S_ERW;
          end else begin
            st_q <= FLM_S_IGN;
          end
        end
        FLM_S_ADDR: begin
          addr_q <= {addr_q[10:0], byte_in};
          acnt_q <= acnt_q + 2'h1;
          if (acnt_q == FLM_ADDR_LAST) begin
            if (cmd_q == FLM_OP_READ) begin
              st_q <= FLM_S_READ;
            end else if (cmd_q == FLM_OP_PAGE) begin
              st_q <= (wel_q && !is_prot(prot_q, {addr_q[10:0], byte_in})) ?
                      FLM_S_PROG : FLM_S_IGN;
            end else begin
              st_q <= FLM_S_ERW;
            end
          end
        end
        FLM_S_PROG: begin
          // wrap inside the page, so bytes never leave it
          addr_q[7:0] <= addr_q[7:0] + 8'h1;
          if (pcnt_q != FLM_PAGE_MAX) begin
            pcnt_q <= pcnt_q + 9'h1;
          end
        end
        FLM_S_WRST: st_q <= FLM_S_IGN;
        FLM_S_READ, FLM_S_STAT, FLM_S_ERW, FLM_S_IGN: st_q <= st_q;
        default: st_q <= FLM_S_IGN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // erase start needs whole bytes, an unlock, and an unguarded target
  always_comb begin
    go_mask = FLM_SECT_MASK;
    if (cmd_q == FLM_OP_BLK) begin
      go_mask = FLM_BLK_MASK;
    end else if (cmd_q == FLM_OP_CHIP) begin
      go_mask = FLM_CHIP_MASK;
    end
  end

  assign er_go = cs_rise && st_q == FLM_S_ERW && rx_cnt_q == 3'h0 && wel_q &&
                 ((cmd_q == FLM_OP_CHIP) ? (prot_q == FLM_PROT_RST) :
                  !is_prot(prot_q, addr_q));
  assign er_last = ((er_addr_q & er_mask_q) == er_mask_q);
  // the walk ignores select, so a deselect cannot cut it short
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      busy_q    <= 1'b0;
      er_addr_q <= 19'h0;
      er_mask_q <= 19'h0;
    end else if (er_go) begin
      busy_q    <= 1'b1;
      er_mask_q <= go_mask;
      er_addr_q <= addr_q & ~go_mask;
    end else if (busy_q) begin
      er_addr_q <= er_addr_q + 19'h1;
      busy_q    <= !er_last;
    end
  end
  // one port: erase walk, program byte, otherwise read at the address
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      mem_we_q   <= 1'b0;
      mem_and_q  <= 1'b1;
      mem_addr_q <= 19'h0;
      mem_wd_q   <= 8'h0;
    end else if (busy_q) begin
      mem_we_q   <= 1'b1;
      mem_and_q  <= 1'b0;
      mem_addr_q <= er_addr_q;
      mem_wd_q   <= FLM_ERASED;
    end else begin
      mem_we_q   <= byte_done && st_q == FLM_S_PROG && pcnt_q != FLM_PAGE_MAX;
      mem_and_q  <= 1'b1;
      mem_addr_q <= addr_q;
      mem_wd_q   <= byte_in;
    end
  end
  flm_array u_array (
    .i_mclk  (i_mclk),
    .i_we    (mem_we_q),
    .i_and   (mem_and_q),
    .i_addr  (mem_addr_q),
    .i_wdata (mem_wd_q),
    .o_rdata (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // status bits are volatile here; no non-volatile cell is modelled
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wel_q      <= 1'b0;
      prot_q     <= FLM_PROT_RST;
      lock_q     <= 1'b0;
      wst_q      <= 8'h0;
      wst_pend_q <= 1'b0;
    end else begin
      if (byte_done && st_q == FLM_S_WRST) begin
        wst_q      <= byte_in;
        wst_pend_q <= 1'b1;
      end else if (cs_rise) begin
        wst_pend_q <= 1'b0;
      end
      if (cs_rise && wst_pend_q && wel_q && rx_cnt_q == 3'h0 && wp_sy_q[1]) begin
        prot_q <= wst_q[FLM_ST_PROT +: 3];
        lock_q <= wst_q[FLM_ST_LOCK];
      end
      if (byte_done && st_q == FLM_S_CMD && !busy_q && byte_in == FLM_OP_UNLOCK) begin
        wel_q <= 1'b1;
      end else if (byte_done && st_q == FLM_S_CMD && !busy_q && byte_in == FLM_OP_LOCK) begin
        wel_q <= 1'b0;
      end else if (cs_rise && (st_q == FLM_S_PROG || st_q == FLM_S_ERW || wst_pend_q)) begin
        wel_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status                         = 8'h0;
    status[FLM_ST_BUSY]            = busy_q;
    status[FLM_ST_WEL]             = wel_q;
    status[FLM_ST_PROT +: 3]       = prot_q;
    status[FLM_ST_LOCK]            = lock_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign src = (st_q == FLM_S_STAT) ? status : mem_rd;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_so   <= 1'b0;
      sh_q   <= 7'h0;
      ocnt_q <= 3'h0;
    end else if (cs_s) begin
      ocnt_q <= 3'h0;
    end else if (act && sclk_fall && (st_q == FLM_S_READ || st_q == FLM_S_STAT)) begin
      ocnt_q <= ocnt_q + 3'h1;
      if (ocnt_q == 3'h0) begin
        o_so <= src[7];
        sh_q <= src[6:0];
      end else begin
        o_so <= sh_q[6];
        sh_q <= {sh_q[5:0], 1'b0};
      end
    end
  end
  assign o_so_oe  = act && (st_q == FLM_S_READ || st_q == FLM_S_STAT);
  assign o_busy   = busy_q;
  assign o_status = status;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_erase_start;
    er_go ##1 busy_q;
  endsequence
  chk_desel_float: assert property (cs_s |-> !o_so_oe)
    else $error("output driven while deselected");
  chk_pause_float: assert property (paused_q |-> !o_so_oe)
    else $error("output driven during pause");
  chk_so_on_fall: assert property ($changed(o_so) |-> $past(sclk_fall))
    else $error("output bit changed off a falling edge");
  chk_rx_on_rise: assert property ($changed(rx_cnt_q) && !$past(cs_s) |-> $past(sclk_rise))
    else $error("bit captured off a rising edge");
  chk_cnt_clear: assert property (cs_s |=> rx_cnt_q == 3'h0)
    else $error("bit counter kept while deselected");
  chk_erase_runs: assert property (s_erase_start |-> busy_q [*8])
    else $error("erase did not keep running");
  chk_busy_hold: assert property (busy_q && !er_last |=> busy_q)
    else $error("erase ended early");
  chk_wp_refuse: assert property (!wp_sy_q[1] |=> $stable(prot_q) && $stable(lock_q))
    else $error("status written while write protected");
  chk_prog_clears: assert property (mem_we_q && !$past(busy_q) |-> mem_and_q)
    else $error("program could set bits");
  chk_not_armed: assert property (!armed_q |-> st_q == FLM_S_CMD && !mem_we_q)
    else $error("command taken before first select");
  chk_page_stay: assert property (mem_we_q && !$past(busy_q) |->
                                  mem_addr_q[18:8] == addr_q[18:8])
    else $error("program left its page");
  chk_erase_guard: assert property (busy_q |-> !is_prot(prot_q, er_addr_q))
    else $error("erase inside a guarded range");
  chk_unlock_need: assert property (er_go |-> $past(wel_q))
    else $error("erase without unlock");

endmodule : flm_spi_flash

// file: sim/flm_spi_master.sv
`timescale 1ns/100ps
module flm_spi_master (
  input  wire logic i_mclk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n
);
  logic mode3;
  logic oe_seen;

  initial begin
    o_sclk   = 1'b0;
    o_cs_n   = 1'b1;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
    mode3    = 1'b0;
    oe_seen  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // half of the 160 ns link period, counted on mclk falls
  task automatic half();
    repeat (8) @(negedge i_mclk);
  endtask : half

  task automatic set_mode(input logic m);
    mode3  = m;
    o_sclk = m;
    half();
  endtask : set_mode

  task automatic sel();
    o_cs_n = 1'b0;
    half();
  endtask : sel

  // released data line shows the inverse so a stale bit never looks valid
  task automatic desel();
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    half();
  endtask : desel

  // nb bits msb first; hold_at picks the bit at which to pause mid-byte
  task automatic xbyte(input logic [7:0] tx, input int nb, input int hold_at,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      o_sclk = 1'b0;
      o_si   = tx[i];
      half();
      if (i == hold_at) begin
        o_hold_n = 1'b0;
        half();
        oe_seen = i_so_oe;
        o_sclk  = 1'b1;
        o_si    = ~o_si;
        half();
        o_sclk = 1'b0;
        half();
        o_si     = tx[i];
        o_hold_n = 1'b1;
        half();
      end
      o_sclk = 1'b1;
      rx[i]  = i_so_oe ? i_so : 1'b1;
      half();
    end
    if (!mode3) begin
      o_sclk = 1'b0;
      half();
    end
  endtask : xbyte
endmodule : flm_spi_master

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
  import flm_pkg::*;
  typedef struct packed {
    logic m3; logic [7:0] op; logic [2:0] k; logic [23:0] a;
    logic [7:0] d; logic b; logic [7:0] st;
  } flm_row_s;

  // k: 0 command only, 1 read one byte, 2 write one byte, 3 erase, 4 status write
  localparam flm_row_s ROWS [22] = '{
    '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02}, '{1, 8'h04, 0, 24'h0, 8'h00, 0, 8'h00},
    '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02}, '{0, 8'h20, 3, 24'h0, 8'h00, 1, 8'h00},
    '{1, 8'h03, 1, 24'hfff, 8'hff, 0, 8'h00}, '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02},
    '{0, 8'h02, 2, 24'hff, 8'ha5, 0, 8'h00}, '{0, 8'h03, 1, 24'hff, 8'ha5, 0, 8'h00},
    '{1, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02}, '{1, 8'h02, 2, 24'hff, 8'h5a, 0, 8'h00},
    '{0, 8'h03, 1, 24'hff, 8'h00, 0, 8'h00}, '{0, 8'h20, 3, 24'h0, 8'h00, 0, 8'h00},
    '{0, 8'h03, 1, 24'hff, 8'h00, 0, 8'h00}, '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02},
    '{0, 8'h01, 4, 24'h0, 8'h04, 0, 8'h04}, '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h06},
    '{0, 8'hd8, 3, 24'h70000, 8'h00, 0, 8'h04}, '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h06},
    '{0, 8'hc7, 0, 24'h0, 8'h00, 0, 8'h04}, '{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h06},
    '{0, 8'h01, 4, 24'h0, 8'h00, 0, 8'h00}, '{1, 8'h03, 1, 24'h80, 8'hff, 0, 8'h00}};

  logic       mclk;
  logic       rstn;
  logic       wp_n;
  logic       sclk;
  logic       cs_n;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic       busy;
  logic [7:0] status;
  logic [7:0] x;
  int         n_fail;
  int         n_tests;

  flm_spi_flash dut_u (.i_mclk(mclk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_in(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
    .o_busy(busy), .o_status(status));
  flm_spi_master m_u (.i_mclk(mclk), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic bx(input logic [7:0] t, output logic [7:0] r);
    m_u.xbyte(t, 8, 9, r);
  endtask : bx

  task automatic adr(input logic [23:0] a);
    logic [7:0] r;
    bx(a[23:16], r);
    bx(a[15:8], r);
    bx(a[7:0], r);
  endtask : adr

  // erase walks the whole range, so the wait is bounded by a sector's length
  task automatic idle();
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge mclk);
    chk({7'h0, busy}, 8'h00);
  endtask : idle

  task automatic do_row(input flm_row_s r);
    logic [7:0] y;
    m_u.set_mode(r.m3);
    m_u.sel();
    bx(r.op, y);
    if (r.k != 0 && r.k != 4) adr(r.a);
    if (r.k == 2 || r.k == 4) bx(r.d, y);
    if (r.k == 1) begin
      bx(8'h00, y);
      chk(y, r.d);
    end
    m_u.desel();
    repeat (4) @(negedge mclk);
    chk({7'h0, busy}, {7'h0, r.b});
    idle();
    chk(status, r.st);
  endtask : do_row

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #600000;
    n_fail++;
    wrap_up();
  end

  initial begin
    rstn    = 1'b0;
    wp_n    = 1'b1;
    n_fail  = 0;
    n_tests = 0;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    chk(status, 8'h00);
    chk({6'h0, so_oe, busy}, 8'h00);
    $display("reset test done");
    foreach (ROWS[i]) begin
      do_row(ROWS[i]);
      $display("row %0d done", i);
    end
    // page write runs past the page end and must wrap inside it
    do_row(flm_row_s'{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02});
    m_u.sel();
    bx(8'h02, x);
    adr(24'hfe);
    bx(8'h3c, x);
    bx(8'h81, x);
    bx(8'h7e, x);
    m_u.desel();
    m_u.sel();
    bx(8'h03, x);
    adr(24'hfe);
    bx(8'h00, x);
    chk(x, 8'h3c);
    bx(8'h00, x);
    chk(x, 8'h00);
    m_u.desel();
    do_row(flm_row_s'{0, 8'h03, 1, 24'h0, 8'h7e, 0, 8'h00});
    $display("page wrap test done");
    wp_n = 1'b0;
    do_row(flm_row_s'{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02});
    do_row(flm_row_s'{0, 8'h01, 4, 24'h0, 8'h1c, 0, 8'h00});
    wp_n = 1'b1;
    $display("write protect test done");
    do_row(flm_row_s'{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02});
    m_u.sel();
    bx(8'h05, x);
    m_u.xbyte(8'h00, 8, 3, x);
    chk(x, 8'h02);
    chk({7'h0, m_u.oe_seen}, 8'h00);
    chk({7'h0, so_oe}, 8'h01);
    m_u.desel();
    chk({7'h0, so_oe}, 8'h00);
    $display("pause test done");
    m_u.sel();
    m_u.xbyte(8'h04, 5, 9, x);
    m_u.desel();
    m_u.sel();
    bx(8'h05, x);
    bx(8'h00, x);
    chk(x, 8'h02);
    m_u.desel();
    $display("partial frame test done");
    // select held low through a reset must not count as a select edge
    m_u.sel();
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    chk({6'h0, so_oe, busy}, 8'h00);
    bx(8'h06, x);
    chk(status, 8'h00);
    m_u.desel();
    do_row(flm_row_s'{0, 8'h06, 0, 24'h0, 8'h00, 0, 8'h02});
    $display("rearm test done");
    wrap_up();
  end
endmodule : tb
